// file: verilog/vrs_status_regs.v
// vrs_status_regs.v: serial command port, status, path configuration and
// start pointer registers, with command acceptance and a one-entry preset buffer.
// assumes a recording core that reports op_done, eom, row address and effects,
// and a host acting as mode 0 serial master.
`timescale 1ns/1ps
`include "vrs_map.vh"
module vrs_status_regs (
	input wire clk,
	input wire arst_n,
	input wire spi_ss_n,
	input wire spi_sck,
	input wire spi_mosi,
	output wire spi_miso,
	input wire [10:0] row_addr,
	input wire op_done,
	input wire eom_detect,
	input wire memory_full,
	input wire [3:0] effect_set,
	input wire [3:0] effect_clr,
	output reg op_start,
	output reg [1:0] op_kind,
	output reg op_stop,
	output reg [10:0] op_start_addr,
	output reg powered_up,
	output reg [11:0] analog_path_config
);
	// ****************************************************************
	// state
	// ****************************************************************
	reg ss_prev_reg;
	reg [2:0] byte_idx_reg;
	reg [7:0] opcode_reg;
	reg [7:0] data1_reg;
	reg [7:0] data2_reg;
	reg [7:0] data3_reg;
	reg [7:0] tx_byte_reg;
	reg tx_load_reg;
	reg [1:0] op_mode_reg;
	reg op_preset_reg;
	reg buf_full_reg;
	reg [1:0] buf_kind_reg;
	reg [10:0] buf_addr_reg;
	reg [3:0] effect_reg;
	reg cmd_err_reg;
	reg int_reg;
	reg eom_reg;
	reg [10:0] start_ptr_reg;
	wire [7:0] rx_byte;
	wire rx_done;
	wire accept;
	wire ready;
	wire frame_start;
	wire frame_end;
	wire [15:0] primary_status;
	wire [7:0] secondary_status;

	assign frame_start = ss_prev_reg & ~spi_ss_n;
	assign frame_end = ~ss_prev_reg & spi_ss_n;

	// ****************************************************************
	// status words
	// ****************************************************************
	// primary status: row address on top, flags below
	assign primary_status = {row_addr, int_reg, eom_reg, powered_up, memory_full, cmd_err_reg};
	// one-hot activity from a single mode code
	assign secondary_status = {effect_reg,
		(op_mode_reg == `VRS_MODE_CAPTURE),
		(op_mode_reg == `VRS_MODE_PLAY),
		(op_mode_reg == `VRS_MODE_ERASE),
		ready};

	// response byte for a frame position and opcode
	function [7:0] resp_byte;
		input [2:0] idx;
		input [7:0] op;
		input [15:0] ps;
		input [7:0] ss;
		input [11:0] cfg;
		input [10:0] ptr;
		begin
			resp_byte = 8'h00;
			case (idx)
			3'd0: resp_byte = ps[7:0];
			3'd1: resp_byte = ps[15:8];
			3'd2: begin
				if (op == `VRS_OP_READ_STATUS)
					resp_byte = ss;
				else if (op == `VRS_OP_READ_START_PTR)
					resp_byte = ptr[7:0];
				else if (op == `VRS_OP_READ_PATH_CFG)
					resp_byte = cfg[7:0];
			end
			3'd3: begin
				if (op == `VRS_OP_READ_START_PTR)
					resp_byte = {5'h00, ptr[10:8]};
				else if (op == `VRS_OP_READ_PATH_CFG)
					resp_byte = {4'h0, cfg[11:8]};
			end
			default: resp_byte = 8'h00;
			endcase
		end
	endfunction

	// preset opcode to operation code
	function [1:0] preset_kind;
		input [7:0] op;
		begin
			case (op)
			`VRS_OP_PRESET_CAPTURE: preset_kind = `VRS_MODE_CAPTURE;
			`VRS_OP_PRESET_AUDIO_OUT: preset_kind = `VRS_MODE_PLAY;
			default: preset_kind = `VRS_MODE_ERASE;
			endcase
		end
	endfunction

	// ****************************************************************
	// submodules
	// ****************************************************************
	vrs_spi_shift u_shift (
		.clk(clk),
		.arst_n(arst_n),
		.ss_n(spi_ss_n),
		.sck(spi_sck),
		.mosi(spi_mosi),
		.tx_byte(tx_byte_reg),
		.tx_load(tx_load_reg),
		.rx_byte(rx_byte),
		.rx_done(rx_done),
		.miso(spi_miso)
	);

	vrs_cmd_gate u_gate (
		.opcode(opcode_reg),
		.nbytes(byte_idx_reg),
		.op_mode(op_mode_reg),
		.op_preset(op_preset_reg),
		.buf_full(buf_full_reg),
		.accept(accept),
		.ready(ready)
	);

	// ****************************************************************
	// frame capture and response loading
	// ****************************************************************
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ss_prev_reg <= 1'b1;
			byte_idx_reg <= 3'd0;
			opcode_reg <= 8'h00;
			data1_reg <= 8'h00;
			data2_reg <= 8'h00;
			data3_reg <= 8'h00;
			tx_byte_reg <= 8'h00;
			tx_load_reg <= 1'b0;
		end else begin
			ss_prev_reg <= spi_ss_n;
			tx_load_reg <= 1'b0;
			if (frame_start) begin
				byte_idx_reg <= 3'd0;
				tx_byte_reg <= resp_byte(3'd0, 8'h00, primary_status, secondary_status,
					analog_path_config, start_ptr_reg);
				tx_load_reg <= 1'b1;
			end else if (rx_done) begin
				case (byte_idx_reg)
				3'd0: opcode_reg <= rx_byte;
				3'd1: data1_reg <= rx_byte;
				3'd2: data2_reg <= rx_byte;
				3'd3: data3_reg <= rx_byte;
				default: data3_reg <= data3_reg;
				endcase
				if (byte_idx_reg != 3'd7)
					byte_idx_reg <= byte_idx_reg + 3'd1;
				tx_byte_reg <= resp_byte(byte_idx_reg + 3'd1,
					(byte_idx_reg == 3'd0) ? rx_byte : opcode_reg,
					primary_status, secondary_status, analog_path_config, start_ptr_reg);
				tx_load_reg <= 1'b1;
			end
		end
	end

	// ****************************************************************
	// effect flags: set wins over clear
	// ****************************************************************
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			effect_reg <= 4'h0;
		end else begin
			effect_reg <= (effect_reg & ~{effect_clr[0], effect_clr[1], effect_clr[2],
				effect_clr[3]}) | {effect_set[0], effect_set[1], effect_set[2],
				effect_set[3]};
		end
	end

	// ****************************************************************
	// command execution and operation engine
	// ****************************************************************
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			op_mode_reg <= `VRS_MODE_IDLE;
			op_preset_reg <= 1'b0;
			buf_full_reg <= 1'b0;
			buf_kind_reg <= `VRS_MODE_IDLE;
			buf_addr_reg <= 11'h000;
			cmd_err_reg <= 1'b0;
			int_reg <= 1'b0;
			eom_reg <= 1'b0;
			start_ptr_reg <= `VRS_START_PTR_RST;
			analog_path_config <= `VRS_PATH_CFG_RST;
			powered_up <= 1'b0;
			op_start <= 1'b0;
			op_kind <= `VRS_MODE_IDLE;
			op_stop <= 1'b0;
			op_start_addr <= 11'h000;
		end else begin
			op_start <= 1'b0;
			op_stop <= 1'b0;
			// operation end from the core, buffered preset follows
			if (op_done && (op_mode_reg != `VRS_MODE_IDLE)) begin
				if (buf_full_reg) begin
					op_mode_reg <= buf_kind_reg;
					op_kind <= buf_kind_reg;
					op_start_addr <= buf_addr_reg;
					op_start <= 1'b1;
					buf_full_reg <= 1'b0;
					if (buf_kind_reg == `VRS_MODE_CAPTURE)
						start_ptr_reg <= buf_addr_reg;
				end else begin
					op_mode_reg <= `VRS_MODE_IDLE;
					op_preset_reg <= 1'b0;
				end
			end
			if (frame_end && (byte_idx_reg != 3'd0)) begin
				cmd_err_reg <= ~accept;
				if (accept) begin
					case (opcode_reg)
					`VRS_OP_POWER_UP: powered_up <= 1'b1;
					`VRS_OP_STOP: begin
						op_mode_reg <= `VRS_MODE_IDLE;
						op_preset_reg <= 1'b0;
						buf_full_reg <= 1'b0;
						op_stop <= 1'b1;
					end
					`VRS_OP_RESET: begin
						op_mode_reg <= `VRS_MODE_IDLE;
						op_preset_reg <= 1'b0;
						buf_full_reg <= 1'b0;
						op_stop <= (op_mode_reg != `VRS_MODE_IDLE);
						start_ptr_reg <= `VRS_START_PTR_RST;
					end
					`VRS_OP_POWER_DOWN: begin
						op_mode_reg <= `VRS_MODE_IDLE;
						op_preset_reg <= 1'b0;
						buf_full_reg <= 1'b0;
						op_stop <= (op_mode_reg != `VRS_MODE_IDLE);
						powered_up <= 1'b0;
					end
					`VRS_OP_PLAY, `VRS_OP_CAPTURE, `VRS_OP_ERASE: begin
						op_mode_reg <= opcode_reg[1:0] + 2'b10 == 2'b10 ? `VRS_MODE_PLAY :
							(opcode_reg[1:0] == 2'b01 ? `VRS_MODE_CAPTURE : `VRS_MODE_ERASE);
						op_kind <= opcode_reg[1:0] == 2'b00 ? `VRS_MODE_PLAY :
							(opcode_reg[1:0] == 2'b01 ? `VRS_MODE_CAPTURE : `VRS_MODE_ERASE);
						op_start_addr <= row_addr;
						op_start <= 1'b1;
						op_preset_reg <= 1'b0;
						if (opcode_reg == `VRS_OP_CAPTURE)
							start_ptr_reg <= row_addr;
					end
					`VRS_OP_NEXT_MESSAGE: start_ptr_reg <= row_addr;
					`VRS_OP_LOAD_PATH_CFG: analog_path_config <=
						{data2_reg[3:0], data1_reg};
					`VRS_OP_PRESET_AUDIO_OUT, `VRS_OP_PRESET_CAPTURE,
					`VRS_OP_PRESET_ERASE: begin
						if (op_mode_reg == `VRS_MODE_IDLE) begin
							op_mode_reg <= preset_kind(opcode_reg);
							op_kind <= preset_kind(opcode_reg);
							op_start_addr <= {data3_reg[2:0], data2_reg};
							op_start <= 1'b1;
							op_preset_reg <= 1'b1;
							if (opcode_reg == `VRS_OP_PRESET_CAPTURE)
								start_ptr_reg <= {data3_reg[2:0], data2_reg};
						end else begin
							buf_full_reg <= 1'b1;
							buf_kind_reg <= preset_kind(opcode_reg);
							buf_addr_reg <= {data3_reg[2:0], data2_reg};
						end
					end
					default: powered_up <= powered_up;
					endcase
				end
			end
			// event flags: set wins over clear
			if (frame_end && accept && (opcode_reg == `VRS_OP_CLEAR_EVENT) &&
					(byte_idx_reg != 3'd0)) begin
				int_reg <= op_done && (op_mode_reg != `VRS_MODE_IDLE); // set wins over clear
				eom_reg <= eom_detect;
			end else begin
				int_reg <= int_reg | (op_done && (op_mode_reg != `VRS_MODE_IDLE));
				eom_reg <= eom_reg | eom_detect;
			end
		end
	end
endmodule // vrs_status_regs

// file: verilog/vrs_map.vh
// vrs_map.vh: opcodes, field positions, reset values and frame lengths of the
// voice recorder status register bank.
// assumes inclusion by the design files of the bank; holds definitions only.
`ifndef VRS_MAP_VH
`define VRS_MAP_VH

// ****************************************************************
// command opcodes
// ****************************************************************
`define VRS_OP_POWER_UP 8'h01
`define VRS_OP_STOP 8'h02
`define VRS_OP_RESET 8'h03
`define VRS_OP_CLEAR_EVENT 8'h04
`define VRS_OP_READ_STATUS 8'h05
`define VRS_OP_READ_START_PTR 8'h06
`define VRS_OP_POWER_DOWN 8'h07
`define VRS_OP_PLAY 8'h40
`define VRS_OP_CAPTURE 8'h41
`define VRS_OP_ERASE 8'h42
`define VRS_OP_READ_PATH_CFG 8'h44
`define VRS_OP_LOAD_PATH_CFG 8'h45
`define VRS_OP_NEXT_MESSAGE 8'h48
`define VRS_OP_PRESET_AUDIO_OUT 8'h80
`define VRS_OP_PRESET_CAPTURE 8'h81
`define VRS_OP_PRESET_ERASE 8'h82

// ****************************************************************
// least bytes per frame
// ****************************************************************
`define VRS_LEN_SHORT 3'd2
`define VRS_LEN_LOAD 3'd3
`define VRS_LEN_PRESET 3'd4

// ****************************************************************
// operation codes and field positions
// ****************************************************************
`define VRS_MODE_IDLE 2'b00
`define VRS_MODE_CAPTURE 2'b01
`define VRS_MODE_PLAY 2'b10
`define VRS_MODE_ERASE 2'b11
`define VRS_PS_ERR_BIT 0
`define VRS_PS_FULL_BIT 1
`define VRS_PS_PU_BIT 2
`define VRS_PS_EOM_BIT 3
`define VRS_PS_INT_BIT 4

// ****************************************************************
// reset values
// ****************************************************************
`define VRS_PATH_CFG_RST 12'h000
`define VRS_START_PTR_RST 11'h000

`endif

// file: verilog/vrs_spi_shift.v
// vrs_spi_shift.v: byte shifter of the serial command port.
// assumes sck, mosi and ss_n synchronous to clk, sck half period of 2+ clocks,
// mode 0, least significant bit first.
`timescale 1ns/1ps
module vrs_spi_shift (
	input wire clk,
	input wire arst_n,
	input wire ss_n,
	input wire sck,
	input wire mosi,
	input wire [7:0] tx_byte,
	input wire tx_load,
	output reg [7:0] rx_byte,
	output reg rx_done,
	output reg miso
);
	reg sck_prev_reg;
	reg [2:0] bit_cnt_reg;
	reg [7:0] rx_sr_reg;
	reg [7:0] tx_sr_reg;
	wire rise;
	wire fall;

	assign rise = sck & ~sck_prev_reg & ~ss_n;
	assign fall = ~sck & sck_prev_reg & ~ss_n;

	// ****************************************************************
	// receive on rising edge, present next bit on falling edge
	// ****************************************************************
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			sck_prev_reg <= 1'b0;
			bit_cnt_reg <= 3'd0;
			rx_sr_reg <= 8'h00;
			tx_sr_reg <= 8'h00;
			rx_byte <= 8'h00;
			rx_done <= 1'b0;
			miso <= 1'b0;
		end else begin
			sck_prev_reg <= sck;
			rx_done <= 1'b0;
			if (ss_n) begin
				bit_cnt_reg <= 3'd0;
			end else if (rise) begin
				rx_sr_reg <= {mosi, rx_sr_reg[7:1]};
				bit_cnt_reg <= bit_cnt_reg + 3'd1;
				if (bit_cnt_reg == 3'd7) begin
					rx_byte <= {mosi, rx_sr_reg[7:1]};
					rx_done <= 1'b1;
				end
			end
			if (tx_load) begin
				tx_sr_reg <= tx_byte;
				if (bit_cnt_reg == 3'd0)
					miso <= tx_byte[0];
			end else if (fall) begin
				miso <= tx_sr_reg[bit_cnt_reg]; // bit index follows bits received
			end
		end
	end
endmodule // vrs_spi_shift

// file: verilog/vrs_cmd_gate.v
// vrs_cmd_gate.v: decides whether a finished command frame is accepted.
// assumes the caller passes the opcode, bytes received and the live engine state.
`timescale 1ns/1ps
`include "vrs_map.vh"
module vrs_cmd_gate (
	input wire [7:0] opcode,
	input wire [2:0] nbytes,
	input wire [1:0] op_mode,
	input wire op_preset,
	input wire buf_full,
	output reg accept,
	output reg ready
);
	// least frame length of an opcode, 0 for an unknown opcode
	function [2:0] need_len;
		input [7:0] op;
		begin
			case (op)
			`VRS_OP_LOAD_PATH_CFG: need_len = `VRS_LEN_LOAD;
			`VRS_OP_PRESET_AUDIO_OUT, `VRS_OP_PRESET_CAPTURE,
			`VRS_OP_PRESET_ERASE: need_len = `VRS_LEN_PRESET;
			`VRS_OP_POWER_UP, `VRS_OP_STOP, `VRS_OP_RESET, `VRS_OP_CLEAR_EVENT,
			`VRS_OP_READ_STATUS, `VRS_OP_READ_START_PTR, `VRS_OP_POWER_DOWN,
			`VRS_OP_PLAY, `VRS_OP_CAPTURE, `VRS_OP_ERASE, `VRS_OP_READ_PATH_CFG,
			`VRS_OP_NEXT_MESSAGE: need_len = `VRS_LEN_SHORT;
			default: need_len = 3'd0;
			endcase
		end
	endfunction

	reg always_ok;
	reg is_preset;
	reg stop_ok;
	reg busy;

	// acceptance by opcode class and engine state
	always @* begin
		busy = (op_mode != `VRS_MODE_IDLE);
		always_ok = (opcode == `VRS_OP_RESET) || (opcode == `VRS_OP_CLEAR_EVENT) ||
			(opcode == `VRS_OP_READ_STATUS) || (opcode == `VRS_OP_POWER_DOWN);
		is_preset = (opcode == `VRS_OP_PRESET_AUDIO_OUT) ||
			(opcode == `VRS_OP_PRESET_CAPTURE) || (opcode == `VRS_OP_PRESET_ERASE);
		stop_ok = (opcode == `VRS_OP_STOP) &&
			((op_mode == `VRS_MODE_CAPTURE) || (op_mode == `VRS_MODE_PLAY));
		ready = ~busy | (op_preset & ~buf_full);
		accept = 1'b0;
		if ((need_len(opcode) != 3'd0) && (nbytes >= need_len(opcode))) begin
			if (!busy)
				accept = 1'b1;
			else if (always_ok || stop_ok)
				accept = 1'b1;
			else if (op_preset && is_preset && !buf_full)
				accept = 1'b1;
			else
				accept = 1'b0;
		end
	end
endmodule // vrs_cmd_gate

// file: tb/vrs_status_regs_checker.sv
// vrs_status_regs_checker.sv: port timing checks of the status register bank.
// assumes a bind onto vrs_status_regs; one clock domain.
`timescale 1ns/1ps
module vrs_status_regs_checker (
	input logic clk,
	input logic arst_n,
	input logic spi_ss_n,
	input logic spi_sck,
	input logic spi_miso,
	input logic op_start,
	input logic [1:0] op_kind,
	input logic op_stop,
	input logic powered_up,
	input logic [11:0] analog_path_config
);
	// ****
	// clocking and sequences
	// ****
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!arst_n);
	// a strobe that lasts exactly one cycle
	sequence s_once(sig);
		sig ##1 !sig;
	endsequence
	// ****
	// properties
	// ****
	property p_start_pulse;
		op_start |-> s_once(op_start);
	endproperty
	property p_stop_pulse;
		op_stop |-> s_once(op_stop);
	endproperty
	property p_start_kind;
		op_start |-> op_kind != 2'b00;
	endproperty
	property p_one_op;
		op_start |-> !op_stop;
	endproperty
	property p_start_frame;
		op_start |-> $past(spi_ss_n);
	endproperty
	property p_stop_frame;
		op_stop |-> $past(spi_ss_n);
	endproperty
	property p_cfg_frame;
		$changed(analog_path_config) |-> $past(spi_ss_n) && spi_ss_n;
	endproperty
	property p_power_frame;
		$changed(powered_up) |-> $past(spi_ss_n);
	endproperty
	property p_miso_rise;
		$rose(spi_sck) |-> $stable(spi_miso);
	endproperty
	a_start_pulse: assert property (p_start_pulse) else $error("start strobe too long");
	a_stop_pulse: assert property (p_stop_pulse) else $error("stop strobe too long");
	a_start_kind: assert property (p_start_kind) else $error("start with idle kind");
	a_one_op: assert property (p_one_op) else $error("start and stop together");
	a_start_frame: assert property (p_start_frame) else $error("start inside a frame");
	a_stop_frame: assert property (p_stop_frame) else $error("stop inside a frame");
	a_cfg_frame: assert property (p_cfg_frame) else $error("config moved in frame");
	a_power_frame: assert property (p_power_frame) else $error("power moved in frame");
	a_miso_rise: assert property (p_miso_rise) else $error("miso moved at sck rise");
endmodule // vrs_status_regs_checker

bind vrs_status_regs vrs_status_regs_checker u_vrs_status_regs_checker (
	.clk(clk),
	.arst_n(arst_n),
	.spi_ss_n(spi_ss_n),
	.spi_sck(spi_sck),
	.spi_miso(spi_miso),
	.op_start(op_start),
	.op_kind(op_kind),
	.op_stop(op_stop),
	.powered_up(powered_up),
	.analog_path_config(analog_path_config)
);

// file: tb/vrs_host_model.sv
// vrs_host_model.sv: serial master standing in for the host controller.
// assumes clk is the device clock; sck runs only inside frames.
`timescale 1ns/1ps
module vrs_host_model (
	input logic clk,
	output logic ss_n,
	output logic sck,
	output logic mosi,
	input logic miso
);
	// idle lines: deselected, sck low
	initial begin
		ss_n = 1'b1;
		sck = 1'b0;
		mosi = 1'b0;
	end
	// one frame of whole bytes, lsb first, mode 0, sck half period 4 clk
	task automatic xfer(input int nb, input logic [31:0] tx, output logic [31:0] rx);
		int i;
		rx = '0;
		@(posedge clk) #1 ss_n = 1'b0;
		for (i = 0; i < nb * 8; i++) begin
			mosi = tx[i];
			repeat (4) @(posedge clk);
			#1 rx[i] = miso;
			sck = 1'b1;
			repeat (4) @(posedge clk);
			#1 sck = 1'b0;
		end
		repeat (4) @(posedge clk);
		#1 ss_n = 1'b1;
		mosi = ~mosi; // released line shows no stale value
		repeat (4) @(posedge clk);
		#1; // hand back off the clock edge
	endtask
endmodule // vrs_host_model

// file: tb/vrs_status_regs_test.sv
// vrs_status_regs_test.sv: self-checking bench of the status register bank.
// assumes the host model drives the serial port; this bench plays the core.
`timescale 1ns/1ps
`include "vrs_map.vh"
module vrs_status_regs_test;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic [10:0] row_addr = 11'h5a3;
	logic op_done = 1'b0;
	logic eom_detect = 1'b0;
	logic memory_full = 1'b0;
	logic [3:0] effect_set = 4'h0;
	logic [3:0] effect_clr = 4'h0;
	wire spi_ss_n, spi_sck, spi_mosi, spi_miso, op_start, op_stop, powered_up;
	wire [1:0] op_kind;
	wire [10:0] op_start_addr;
	wire [11:0] analog_path_config;
	logic [31:0] rx;
	logic [1:0] got_kind;
	logic [10:0] got_addr;
	int n_start = 0, n_stop = 0, n_fail = 0, checks_done = 0;
	// ****
	// design and host
	// ****
	vrs_status_regs u_vrs_status_regs (.clk(clk), .arst_n(arst_n), .spi_ss_n(spi_ss_n),
		.spi_sck(spi_sck), .spi_mosi(spi_mosi), .spi_miso(spi_miso), .row_addr(row_addr),
		.op_done(op_done), .eom_detect(eom_detect), .memory_full(memory_full),
		.effect_set(effect_set), .effect_clr(effect_clr), .op_start(op_start),
		.op_kind(op_kind), .op_stop(op_stop), .op_start_addr(op_start_addr),
		.powered_up(powered_up), .analog_path_config(analog_path_config));
	vrs_host_model u_vrs_host_model (.clk(clk), .ss_n(spi_ss_n), .sck(spi_sck),
		.mosi(spi_mosi), .miso(spi_miso));
	// clock and tallies of core strobes
	always #5 clk = ~clk;
	always @(posedge clk) begin
		if (op_start) begin
			n_start++;
			got_kind = op_kind;
			got_addr = op_start_addr;
		end
		if (op_stop)
			n_stop++;
	end
	// ****
	// helpers
	// ****
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic cmd(input logic [7:0] op, input int nb, input logic [23:0] d);
		u_vrs_host_model.xfer(nb, {d, op}, rx);
	endtask
	task automatic st();
		cmd(`VRS_OP_READ_STATUS, 3, 24'h0);
	endtask
	// one-cycle strobes from the core
	task automatic core(input logic [3:0] s, input logic [3:0] c, input logic d);
		@(posedge clk) #1 effect_set = s;
		effect_clr = c;
		op_done = d;
		@(posedge clk) #1 effect_set = 4'h0;
		effect_clr = 4'h0;
		op_done = 1'b0;
		repeat (3) @(posedge clk);
	endtask
	// ****
	// scenarios
	// ****
	task automatic t_idle();
		#1 memory_full = 1'b1;
		st();
		chk(rx[23:16], 8'h01);
		chk(rx[1], 1'b1);
		memory_full = 1'b0;
		chk(rx[0], 1'b0);
		chk({rx[15:8], rx[7:5]}, row_addr);
		cmd(`VRS_OP_READ_PATH_CFG, 4, 24'h0);
		chk(rx[27:16], `VRS_PATH_CFG_RST);
		cmd(8'h7f, 2, 24'h0);
		cmd(`VRS_OP_READ_START_PTR, 4, 24'h0);
		chk(rx[0], 1'b1);
		chk(rx[26:16], `VRS_START_PTR_RST);
	endtask
	task automatic t_cfg();
		cmd(`VRS_OP_LOAD_PATH_CFG, 3, 24'h0a5c);
		chk(analog_path_config, 12'ha5c);
		cmd(`VRS_OP_LOAD_PATH_CFG, 2, 24'h0333);
		cmd(`VRS_OP_READ_PATH_CFG, 4, 24'h0);
		chk(rx[0], 1'b1);
		chk(rx[27:16], 12'ha5c);
	endtask
	task automatic t_effects();
		core(4'b0101, 4'b0000, 1'b0);
		st();
		chk(rx[23:16], 8'ha1);
		core(4'b0010, 4'b0001, 1'b0);
		st();
		chk(rx[23:16], 8'h61);
	endtask
	// busy capture refuses a load, then stops
	task automatic t_capture();
		int s;
		cmd(`VRS_OP_POWER_UP, 2, 24'h0);
		chk(powered_up, 1'b1);
		s = n_start;
		cmd(`VRS_OP_CAPTURE, 2, 24'h0);
		chk(n_start - s, 1);
		chk(got_kind, `VRS_MODE_CAPTURE);
		st();
		chk(rx[23:16], 8'h68);
		cmd(`VRS_OP_LOAD_PATH_CFG, 3, 24'h0fff);
		chk(analog_path_config, 12'ha5c);
		st();
		chk(rx[0], 1'b1);
		cmd(`VRS_OP_CLEAR_EVENT, 2, 24'h0);
		s = n_stop;
		cmd(`VRS_OP_STOP, 2, 24'h0);
		chk(rx[0], 1'b0);
		chk(n_stop - s, 1);
		core(4'h0, 4'h0, 1'b1);
		st();
		chk(rx[23:16], 8'h61);
	endtask
	// playback ends by the core, erase refuses stop
	task automatic t_play_erase();
		int s;
		cmd(`VRS_OP_PLAY, 2, 24'h0);
		st();
		chk(rx[23:16], 8'h64);
		core(4'h0, 4'h0, 1'b1);
		st();
		chk(rx[23:16], 8'h61);
		chk(rx[4], 1'b1);
		cmd(`VRS_OP_CLEAR_EVENT, 2, 24'h0);
		cmd(`VRS_OP_ERASE, 2, 24'h0);
		chk(rx[4], 1'b0);
		chk(got_kind, `VRS_MODE_ERASE);
		s = n_stop;
		cmd(`VRS_OP_STOP, 2, 24'h0);
		st();
		chk(n_stop - s, 0);
		chk(rx[0], 1'b1);
		chk(rx[23:16], 8'h62);
		core(4'h0, 4'h0, 1'b1);
	endtask
	// pointer moves, preset queue and stop of the buffered preset playback
	task automatic t_preset();
		int s;
		row_addr = 11'h2ab;
		cmd(`VRS_OP_NEXT_MESSAGE, 2, 24'h0);
		row_addr = 11'h111;
		cmd(`VRS_OP_READ_START_PTR, 4, 24'h0);
		chk(rx[26:16], 11'h2ab);
		cmd(`VRS_OP_RESET, 2, 24'h0);
		cmd(`VRS_OP_READ_START_PTR, 4, 24'h0);
		chk(rx[26:16], 11'h000);
		cmd(`VRS_OP_POWER_UP, 2, 24'h0);
		cmd(`VRS_OP_PRESET_CAPTURE, 4, 24'h015500);
		chk(got_addr, 11'h155);
		st();
		chk(rx[19:16], 4'h9);
		cmd(`VRS_OP_PRESET_AUDIO_OUT, 4, 24'h003300);
		st();
		chk(rx[19:16], 4'h8);
		cmd(`VRS_OP_PRESET_ERASE, 4, 24'h007700);
		st();
		chk(rx[0], 1'b1);
		core(4'h0, 4'h0, 1'b1);
		chk(got_kind, `VRS_MODE_PLAY);
		chk(got_addr, 11'h033);
		s = n_stop;
		cmd(`VRS_OP_STOP, 2, 24'h0);
		chk(n_stop - s, 1);
		core(4'h0, 4'h0, 1'b1);
		cmd(`VRS_OP_READ_START_PTR, 4, 24'h0);
		chk(rx[26:16], 11'h155);
		cmd(`VRS_OP_POWER_DOWN, 2, 24'h0);
		chk(powered_up, 1'b0);
	endtask
	// ****
	// sequence and verdict
	// ****
	task automatic report_and_stop();
		if (n_fail == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		repeat (8) @(posedge clk);
		#1 arst_n = 1'b1;
		repeat (2) @(posedge clk);
		t_idle();
		t_cfg();
		t_effects();
		t_capture();
		t_play_erase();
		t_preset();
		report_and_stop();
	end
	// watchdog well beyond the expected run
	initial begin
		#600000;
		n_fail++;
		report_and_stop();
	end
endmodule // vrs_status_regs_test
